// file: hdl/vhbi_pkg.sv
package vhbi_pkg;

    // ------------------------------------------------------------
    // Address map
    // ------------------------------------------------------------
    localparam logic [19:0] VHBI_MEM_BASE = 20'ha0000;
    localparam logic [19:0] VHBI_MEM_LAST = 20'hbffff;
    localparam logic [19:0] VHBI_ROM_BASE = 20'hc0000;
    localparam logic [19:0] VHBI_ROM_LAST = 20'hc7fff;
    localparam int VHBI_ROM_PAGE_BIT = 14;
    localparam logic [15:0] VHBI_IO_SETUP = 16'h46e8;
    localparam logic [15:0] VHBI_IO_ENABLE = 16'h0102;
    localparam logic [15:0] VHBI_IO_LOW = 16'h03b0;
    localparam logic [15:0] VHBI_IO_HIGH = 16'h03df;

    // ------------------------------------------------------------
    // Power-up configuration
    // ------------------------------------------------------------
    localparam int VHBI_CFG_BUS_BIT = 2;
    localparam int VHBI_CFG_W16_BIT = 0;
    localparam logic [7:0] VHBI_CFG_RESET = 8'h00;
    localparam logic VHBI_ENABLE_RESET = 1'b1;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int VHBI_CLK_NS = 100;
    localparam int VHBI_RESET_MIN_PERIODS = 10;
    localparam int VHBI_SLOT_CYCLES = 4;
    localparam int VHBI_MEM_ACCESS_CYCLES = 2;
    localparam int VHBI_FIFO_DEPTH = 8;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        VHBI_MODE_TEXT = 2'h0,
        VHBI_MODE_PLANAR = 2'h1,
        VHBI_MODE_PACKED = 2'h2
    } vhbi_mode_e;

    typedef struct packed {
        logic mem_rd;
        logic mem_wr;
        logic io_rd;
        logic io_wr;
        logic bhe;
        logic [19:0] addr;
        logic [15:0] wdata;
    } vhbi_host_req_s;

    typedef struct packed {
        logic req;
        logic wr;
        logic wide;
        logic [19:0] addr;
        logic [15:0] wdata;
    } vhbi_mem_req_s;

endpackage

// file: hdl/vhbi_sync.sv
`timescale 1ns/1ps
module vhbi_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic resetn_i,
    // Data
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            sync_o <= '0;
        end else begin
            s1_r <= async_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            for (int i = 0; i < WIDTH; i++) begin
                if (s2_r[i] == s3_r[i]) begin
                    sync_o[i] <= s3_r[i];
                end
            end
        end
    end
endmodule // vhbi_sync

// file: hdl/vhbi_host_if.sv
`timescale 1ns/1ps
module vhbi_host_if
    import vhbi_pkg::*;
#(
    parameter int SLOT_CYCLES = VHBI_SLOT_CYCLES,
    parameter int ACCESS_CYCLES = VHBI_MEM_ACCESS_CYCLES,
    parameter int FIFO_DEPTH = VHBI_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic resetn_i,
    // Host bus pins
    input wire vhbi_host_req_s host_i,
    input wire logic display_memory_enable_i,
    input wire logic [7:0] video_memory_data_pins_i,
    input wire logic sys_bus16_i,
    input wire vhbi_mode_e mode_i,
    output logic [15:0] host_rdata_o,
    output logic rdy_o,
    output logic ds16_n_o,
    output logic rom_en_n_o,
    output logic rom_page_o,
    output logic channel_mode_o,
    output logic subsys_enable_o,
    // Display memory side
    output vhbi_mem_req_s mem_o,
    input wire logic [15:0] mem_rdata_i,
    input wire logic mem_done_i,
    // Display fetch side
    input wire logic fetch_valid_i,
    input wire logic [15:0] fetch_data_i,
    output logic fetch_ready_o,
    input wire logic disp_ready_i,
    output logic disp_valid_o,
    output logic [15:0] disp_data_o,
    // Sequencer clocks
    output logic char_clk_o,
    output logic dot_clk_o
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    localparam int HW = $bits(vhbi_host_req_s);
    vhbi_host_req_s host_s;
    logic enable_s;
    logic bus16_s;

    vhbi_sync #(.WIDTH(HW + 2)) u_sync (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .async_i({host_i, display_memory_enable_i, sys_bus16_i}),
        .sync_o({host_s, enable_s, bus16_s})
    );

    // ------------------------------------------------------------
    // Power-up configuration capture
    // ------------------------------------------------------------
    logic [7:0] power_up_config_register_r;
    logic cfg_loaded_r;

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            power_up_config_register_r <= VHBI_CFG_RESET;
            cfg_loaded_r <= 1'b0;
        end else if (!cfg_loaded_r) begin
            power_up_config_register_r <= video_memory_data_pins_i;
            cfg_loaded_r <= 1'b1;
        end
    end

    logic chan_mode;
    assign chan_mode = power_up_config_register_r[VHBI_CFG_BUS_BIT];
    assign channel_mode_o = chan_mode;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic logic in_range(input logic [19:0] a, input logic [19:0] lo, input logic [19:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    logic mem_cyc;
    logic io_cyc;
    logic hit_mem;
    logic hit_rom;
    logic hit_io;
    logic hit_setup;
    logic hit_enable;
    logic subsys_en_r;

    assign mem_cyc = host_s.mem_rd | host_s.mem_wr;
    assign io_cyc = host_s.io_rd | host_s.io_wr;
    assign hit_setup = io_cyc && (host_s.addr[15:0] == VHBI_IO_SETUP) && !chan_mode;
    assign hit_enable = io_cyc && (host_s.addr[15:0] == VHBI_IO_ENABLE);
    // Channel-style bus: enable gates ports too
    assign hit_io = io_cyc && subsys_en_r && (enable_s || !chan_mode)
        && in_range({4'h0, host_s.addr[15:0]}, {4'h0, VHBI_IO_LOW}, {4'h0, VHBI_IO_HIGH});
    assign hit_mem = mem_cyc && enable_s && subsys_en_r
        && in_range(host_s.addr, VHBI_MEM_BASE, VHBI_MEM_LAST);
    assign hit_rom = host_s.mem_rd && in_range(host_s.addr, VHBI_ROM_BASE, VHBI_ROM_LAST);

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            subsys_en_r <= VHBI_ENABLE_RESET;
        end else if (hit_enable && host_s.io_wr) begin
            subsys_en_r <= host_s.wdata[0];
        end
    end
    assign subsys_enable_o = subsys_en_r;

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rom_en_n_o <= 1'b1;
            rom_page_o <= 1'b0;
        end else begin
            rom_en_n_o <= !hit_rom;
            if (hit_rom) begin
                rom_page_o <= host_s.addr[VHBI_ROM_PAGE_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // Width selection
    // ------------------------------------------------------------
    logic wide_ok;
    assign wide_ok = (mode_i != VHBI_MODE_PLANAR)
        && bus16_s && power_up_config_register_r[VHBI_CFG_W16_BIT];
    assign ds16_n_o = !(hit_mem && wide_ok);

    // ------------------------------------------------------------
    // Sequencer slots and clocks
    // ------------------------------------------------------------
    logic [7:0] slot_cnt_r;
    logic host_slot_r;
    logic slot_start;

    assign slot_start = (slot_cnt_r == 8'(SLOT_CYCLES - 1));

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            slot_cnt_r <= 8'h00;
            host_slot_r <= 1'b0;
            char_clk_o <= 1'b0;
            dot_clk_o <= 1'b0;
        end else begin
            dot_clk_o <= !dot_clk_o;
            slot_cnt_r <= slot_start ? 8'h00 : slot_cnt_r + 8'h01;
            if (slot_start) begin
                host_slot_r <= !host_slot_r;
                char_clk_o <= !char_clk_o;
            end
        end
    end

    // ------------------------------------------------------------
    // Host memory cycle state machine
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_WAIT = 4'b0010,
        ST_ACC = 4'b0100,
        ST_DONE = 4'b1000
    } vhbi_state_e;

    vhbi_state_e state_r;
    vhbi_state_e state_nxt;
    logic [7:0] acc_cnt_r;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (hit_mem) begin
                    state_nxt = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (host_slot_r && slot_cnt_r == 8'h00) begin
                    state_nxt = ST_ACC;
                end
            end
            ST_ACC: begin
                if (mem_done_i && acc_cnt_r >= 8'(ACCESS_CYCLES - 1)) begin
                    state_nxt = ST_DONE;
                end
            end
            ST_DONE: begin
                if (!mem_cyc) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_r <= ST_IDLE;
            acc_cnt_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            acc_cnt_r <= (state_r == ST_ACC) ? acc_cnt_r + 8'h01 : 8'h00;
        end
    end

    // Ready low only during memory waits
    assign rdy_o = !(hit_mem && state_r != ST_DONE);

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mem_o <= '0;
        end else begin
            mem_o.req <= (state_nxt == ST_ACC);
            mem_o.wr <= host_s.mem_wr;
            mem_o.wide <= wide_ok && host_s.bhe;
            mem_o.addr <= host_s.addr;
            mem_o.wdata <= host_s.wdata;
        end
    end

    // ------------------------------------------------------------
    // Read data return
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            host_rdata_o <= 16'h0000;
        end else if (state_r == ST_ACC && mem_done_i) begin
            host_rdata_o <= (wide_ok && host_s.bhe) ? mem_rdata_i : {8'h00, mem_rdata_i[7:0]};
        end else if (host_s.io_rd && (hit_io || hit_enable || hit_setup)) begin
            host_rdata_o <= {8'h00, (hit_enable || hit_setup) ? {7'h00, subsys_en_r}
                : power_up_config_register_r};
        end
    end

    // ------------------------------------------------------------
    // Display fetch FIFO
    // ------------------------------------------------------------
    localparam int AW = $clog2(FIFO_DEPTH);
    logic [15:0] fifo_mem [FIFO_DEPTH];
    logic [AW:0] wr_ptr_r;
    logic [AW:0] rd_ptr_r;
    logic full;
    logic empty;

    assign empty = (wr_ptr_r == rd_ptr_r);
    assign full = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
    assign fetch_ready_o = !full && !host_slot_r;
    assign disp_valid_o = !empty;
    assign disp_data_o = fifo_mem[rd_ptr_r[AW-1:0]];

    always_ff @(posedge core_clk_i) begin
        if (fetch_valid_i && fetch_ready_o) begin
            fifo_mem[wr_ptr_r[AW-1:0]] <= fetch_data_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (fetch_valid_i && fetch_ready_o) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (disp_ready_i && !empty) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_io_no_wait;
        @(posedge core_clk_i) disable iff (!resetn_i) (io_cyc || hit_rom) |-> rdy_o;
    endproperty
    a_io_no_wait: assert property (p_io_no_wait) else $error("wait on io or rom");

    property p_mem_wait;
        @(posedge core_clk_i) disable iff (!resetn_i) $rose(hit_mem) |-> !rdy_o;
    endproperty
    a_mem_wait: assert property (p_mem_wait) else $error("memory cycle not stalled");

    property p_slot_only;
        @(posedge core_clk_i) disable iff (!resetn_i) $rose(mem_o.req) |-> host_slot_r;
    endproperty
    a_slot_only: assert property (p_slot_only) else $error("access outside host slot");

    property p_planar_narrow;
        @(posedge core_clk_i) disable iff (!resetn_i) mode_i == VHBI_MODE_PLANAR |-> ds16_n_o;
    endproperty
    a_planar_narrow: assert property (p_planar_narrow) else $error("wide planar access");

    property p_io_narrow;
        @(posedge core_clk_i) disable iff (!resetn_i) $rose(io_cyc && host_s.io_rd && !hit_mem)
            |=> host_rdata_o[15:8] == 8'h00;
    endproperty
    a_io_narrow: assert property (p_io_narrow) else $error("io data wider than byte");

    property p_cfg_hold;
        @(posedge core_clk_i) disable iff (!resetn_i) cfg_loaded_r |=> $stable(power_up_config_register_r);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("config changed after load");

    property p_fifo_full;
        @(posedge core_clk_i) disable iff (!resetn_i) full |-> !fetch_ready_o;
    endproperty
    a_fifo_full: assert property (p_fifo_full) else $error("fifo accepts when full");

    property p_wait_slot;
        @(posedge core_clk_i) disable iff (!resetn_i) state_r == ST_WAIT && !host_slot_r |=> state_r != ST_ACC;
    endproperty
    a_wait_slot: assert property (p_wait_slot) else $error("access in display slot");
endmodule // vhbi_host_if

// file: sim/vhbi_host_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Host bus master model
// ------------------------------------------------------------
module vhbi_host_model
    import vhbi_pkg::*;
(
    // Clock
    input wire logic core_clk_i,
    // Device answers
    input wire logic rdy_i,
    input wire logic [15:0] rdata_i,
    input wire logic ds16_n_i,
    input wire logic rom_en_n_i,
    // Host pins
    output vhbi_host_req_s host_o,
    output logic enable_o
);
    initial begin
        host_o = '0;
        enable_o = 1'b1;
    end

    // One strobe at a time, held for at least seven clocks and then until ready is sampled high
    task automatic cycle(input logic [3:0] kind, input logic [19:0] addr, input logic [15:0] wdata,
                         input logic bhe, input logic en, output logic [15:0] rdata, output int waits,
                         output logic wide, output logic rom);
        int n;
        waits = 0;
        wide = 1'b0;
        rom = 1'b0;
        @(posedge core_clk_i);
        #1;
        enable_o = en;
        host_o = {kind, bhe, addr, wdata};
        for (n = 0; n < 100; n++) begin
            @(posedge core_clk_i);
            wide = wide | !ds16_n_i;
            rom = rom | !rom_en_n_i;
            if (n >= 6 && rdy_i)
                break;
            if (!rdy_i)
                waits++;
        end
        if (n == 100)
            waits = 999;
        rdata = rdata_i;
        #1;
        // Released lines show the inverse of the last value
        host_o = {4'h0, ~bhe, ~addr, ~wdata};
        enable_o = 1'b1;
        repeat (6) @(posedge core_clk_i);
    endtask
endmodule // vhbi_host_model

// file: sim/tb.sv
`timescale 1ns/1ps
module tb;
    import vhbi_pkg::*;
    localparam int WAIT_MAX = 12 + 2 * VHBI_SLOT_CYCLES + VHBI_MEM_ACCESS_CYCLES;
    logic core_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    vhbi_host_req_s host_i;
    logic en_i;
    logic [7:0] pins_i = 8'h01;
    logic sys_bus16_i = 1'b1;
    vhbi_mode_e mode_i = VHBI_MODE_TEXT;
    logic [15:0] host_rdata_o;
    logic rdy_o, ds16_n_o, rom_en_n_o, rom_page_o, channel_mode_o, subsys_enable_o;
    vhbi_mem_req_s mem_o;
    logic [15:0] mem_rdata_i = 16'h0000;
    logic mem_done_i = 1'b0;
    logic fetch_valid_i = 1'b0;
    logic [15:0] fetch_data_i = 16'h0000;
    logic fetch_ready_o, disp_valid_o, char_clk_o, dot_clk_o;
    logic disp_ready_i = 1'b0;
    logic [15:0] disp_data_o;
    logic [15:0] rd;
    logic wd, rm, last_wr, last_wide;
    logic [15:0] last_wdata;
    int wt, acc, n_req;
    int mismatches = 0;
    int n_checks = 0;

    always #50 core_clk_i = ~core_clk_i;

    vhbi_host_if i_dut (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .host_i(host_i),
        .display_memory_enable_i(en_i), .video_memory_data_pins_i(pins_i), .sys_bus16_i(sys_bus16_i),
        .mode_i(mode_i), .host_rdata_o(host_rdata_o), .rdy_o(rdy_o), .ds16_n_o(ds16_n_o),
        .rom_en_n_o(rom_en_n_o), .rom_page_o(rom_page_o), .channel_mode_o(channel_mode_o),
        .subsys_enable_o(subsys_enable_o), .mem_o(mem_o), .mem_rdata_i(mem_rdata_i),
        .mem_done_i(mem_done_i), .fetch_valid_i(fetch_valid_i), .fetch_data_i(fetch_data_i),
        .fetch_ready_o(fetch_ready_o), .disp_ready_i(disp_ready_i), .disp_valid_o(disp_valid_o),
        .disp_data_o(disp_data_o), .char_clk_o(char_clk_o), .dot_clk_o(dot_clk_o));

    vhbi_host_model i_host (.core_clk_i(core_clk_i), .rdy_i(rdy_o), .rdata_i(host_rdata_o),
        .ds16_n_i(ds16_n_o), .rom_en_n_i(rom_en_n_o), .host_o(host_i), .enable_o(en_i));

    // ------------------------------------------------------------
    // Display memory responder
    // ------------------------------------------------------------
    always @(posedge core_clk_i) begin
        #1;
        if (mem_o.req && !mem_done_i) begin
            acc++;
            if (acc >= VHBI_MEM_ACCESS_CYCLES) begin
                mem_done_i = 1'b1;
                mem_rdata_i = {mem_o.addr[7:0], ~mem_o.addr[7:0]};
                last_wr = mem_o.wr;
                last_wide = mem_o.wide;
                last_wdata = mem_o.wdata;
                n_req++;
            end
        end else begin
            mem_done_i = 1'b0;
            mem_rdata_i = ~mem_rdata_i;
            acc = 0;
        end
    end

    // ------------------------------------------------------------
    // Compare, closing, bus and reset tasks
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [19:0] exp, input logic [19:0] got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_rng(input string name, input int lo, input int hi, input int got);
        n_checks++;
        if (got < lo || got > hi) begin
            mismatches++;
            $display("mismatch %s expected %0d..%0d seen %0d", name, lo, hi, got);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic bus(input logic [3:0] kind, input logic [19:0] a, input logic [15:0] d, input logic bhe,
                       input logic en);
        i_host.cycle(kind, a, d, bhe, en, rd, wt, wd, rm);
    endtask

    task automatic do_reset(input logic [7:0] cfg);
        #1;
        resetn_i = 1'b0;
        pins_i = cfg;
        repeat (VHBI_RESET_MIN_PERIODS) @(posedge core_clk_i);
        #1;
        resetn_i = 1'b1;
        repeat (3) @(posedge core_clk_i);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic s_config();
        do_reset(8'h05);
        chk("channel", 20'h1, channel_mode_o);
        do_reset(8'h01);
        chk("channel", 20'h0, channel_mode_o);
        chk("subsys", 20'h1, subsys_enable_o);
    endtask

    task automatic s_io();
        bus(4'h2, 20'h003c0, 16'h0000, 1'b1, 1'b1);
        chk_rng("io waits", 0, 0, wt);
        chk("io data", 20'h0001, rd);
        chk("io wide", 20'h0, wd);
        bus(4'h1, 20'h00102, 16'hff00, 1'b1, 1'b1);
        chk("subsys", 20'h0, subsys_enable_o);
        n_req = 0;
        bus(4'h8, 20'ha0000, 16'h0000, 1'b1, 1'b1);
        chk_rng("disabled req", 0, 0, n_req);
        bus(4'h1, 20'h00102, 16'h0001, 1'b1, 1'b1);
        chk("subsys", 20'h1, subsys_enable_o);
        bus(4'h1, 20'h046e8, 16'h0001, 1'b1, 1'b1);
        chk_rng("setup waits", 0, 0, wt);
        bus(4'h2, 20'h046e8, 16'h0000, 1'b1, 1'b1);
        chk("setup data", 20'h0001, rd);
    endtask

    task automatic s_rom();
        bus(4'h8, 20'hc4000, 16'h0000, 1'b0, 1'b0);
        chk_rng("rom waits", 0, 0, wt);
        chk("rom sel", 20'h1, rm);
        chk("rom page", 20'h1, rom_page_o);
        bus(4'h8, 20'hc0000, 16'h0000, 1'b0, 1'b0);
        chk("rom page", 20'h0, rom_page_o);
    endtask

    task automatic s_mem_wide();
        #1;
        mode_i = VHBI_MODE_TEXT;
        bus(4'h8, 20'ha1234, 16'h0000, 1'b1, 1'b1);
        chk_rng("mem waits", 1, WAIT_MAX, wt);
        chk("mem data", 20'h34cb, rd);
        chk("ds16", 20'h1, wd);
        chk("wide", 20'h1, last_wide);
        bus(4'h8, 20'ha0100, 16'h0000, 1'b1, 1'b1);
        chk_rng("b2b waits", 1, WAIT_MAX, wt);
        chk("b2b data", 20'h00ff, rd);
    endtask

    task automatic s_mem_narrow();
        #1;
        mode_i = VHBI_MODE_PLANAR;
        bus(4'h4, 20'ha2000, 16'h5aa5, 1'b1, 1'b1);
        chk("ds16", 20'h0, wd);
        chk("wide", 20'h0, last_wide);
        chk("write", 20'h1, last_wr);
        chk("wdata", 20'ha5, last_wdata[7:0]);
        #1;
        mode_i = VHBI_MODE_PACKED;
        sys_bus16_i = 1'b0;
        bus(4'h8, 20'ha3000, 16'h0000, 1'b1, 1'b1);
        chk("wide", 20'h0, last_wide);
        #1;
        sys_bus16_i = 1'b1;
        bus(4'h8, 20'ha3000, 16'h0000, 1'b1, 1'b1);
        chk("wide", 20'h1, last_wide);
    endtask

    task automatic s_ignore();
        n_req = 0;
        bus(4'h8, 20'hd0000, 16'h0000, 1'b1, 1'b1);
        chk_rng("outside req", 0, 0, n_req);
        bus(4'h8, 20'ha0000, 16'h0000, 1'b1, 1'b0);
        chk_rng("enable low req", 0, 0, n_req);
        chk_rng("enable low waits", 0, 0, wt);
    endtask

    task automatic s_clocks();
        int dt;
        int ct;
        logic pd;
        logic pc;
        dt = 0;
        ct = 0;
        @(posedge core_clk_i);
        #2;
        pd = dot_clk_o;
        pc = char_clk_o;
        repeat (4 * VHBI_SLOT_CYCLES) begin
            @(posedge core_clk_i);
            #2;
            dt += (dot_clk_o !== pd);
            ct += (char_clk_o !== pc);
            pd = dot_clk_o;
            pc = char_clk_o;
        end
        chk_rng("dot toggles", 4 * VHBI_SLOT_CYCLES, 4 * VHBI_SLOT_CYCLES, dt);
        chk_rng("char toggles", 4, 4, ct);
    endtask

    task automatic s_fifo();
        int n;
        @(posedge core_clk_i);
        for (int i = 0; i < 3; i++) begin
            #1;
            fetch_valid_i = 1'b1;
            fetch_data_i = 16'hc0d0 + 16'(i);
            for (n = 0; n < 50; n++) begin
                @(negedge core_clk_i);
                if (fetch_ready_o === 1'b1)
                    break;
            end
            chk_rng("fetch wait", 0, 49, n);
            @(posedge core_clk_i);
        end
        #1;
        fetch_valid_i = 1'b0;
        fetch_data_i = 16'h3f2f;
        disp_ready_i = 1'b1;
        for (int i = 0; i < 3; i++) begin
            for (n = 0; n < 50; n++) begin
                @(negedge core_clk_i);
                if (disp_valid_o === 1'b1)
                    break;
            end
            chk("disp data", 20'hc0d0 + 20'(i), disp_data_o);
            @(posedge core_clk_i);
        end
        @(negedge core_clk_i);
        chk("disp empty", 20'h0, disp_valid_o);
        disp_ready_i = 1'b0;
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        s_config();
        s_io();
        s_rom();
        s_mem_wide();
        s_mem_narrow();
        s_ignore();
        s_clocks();
        s_fifo();
        report_and_stop();
    end

    initial begin
        #5_000_000;
        mismatches++;
        report_and_stop();
    end
endmodule // tb
